// >>> common/rtc_supervisor_defs.svh
// Purpose: Named offsets, field positions and timing figures.
// Assumes: 25 MHz system clock.
// Notes: Definitions only.
`ifndef RTC_SUPERVISOR_DEFS_SVH
`define RTC_SUPERVISOR_DEFS_SVH

// ==========================================================
// Register addresses
`define ADDR_FLAGS 19'h7FFF0
`define ADDR_AL_SEC 19'h7FFF2
`define ADDR_AL_MIN 19'h7FFF3
`define ADDR_AL_HOUR 19'h7FFF4
`define ADDR_AL_DATE 19'h7FFF5
`define ADDR_AL_MONTH 19'h7FFF6
`define ADDR_WDOG 19'h7FFF7
`define ADDR_DAY 19'h7FFFC

// ==========================================================
// Field positions
`define FLG_WDF 7
`define FLG_AF 6
`define FLG_BL 4
`define RATE_MSB 3
`define MON_AFE 7
`define MON_SQUARE_WAVE_ENABLE 6
`define MON_ABE 5
`define RPT_BIT 7
`define RPT5_BIT 6
`define WD_WDS 7
`define WD_MUL_MSB 6
`define WD_MUL_LSB 2
`define WD_RES_MSB 1
`define DAY_FT 6
`define FT_TAP 6
`define WD_OFF 8'h00

// ==========================================================
// Timing
`define CLK_HZ 25000000
`define CLK_PERIOD_NS 40
`define REC_TIME_MS 40
`define REQ_A_MIN_NS 50
`define REQ_B_MIN_MS 20
`define OSC_TICK_HZ 65536
`define NCO_INC ((64'd`OSC_TICK_HZ << 32) / 64'd`CLK_HZ)
`define DIV_W 18

`endif

// >>> common/rtc_supervisor_pkg.sv
// Purpose: Types shared by the supervisor files.
// Assumes: Nothing.
// Notes: Constants live in the defs header.
package rtc_supervisor_pkg;

    // ======================================================
    // BCD time of the current second
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } bcd_time_t;

    // ======================================================
    // Reset output sequencer
    typedef enum logic [1:0] {
        RST_IDLE,
        RST_HOLD,
        RST_RECOVER
    } rst_state_t;

endpackage

// >>> core/reset_pulse_filter.sv
// Purpose: Qualifies an active-low reset request by its minimum width.
// Assumes: Request is synchronous to the clock.
// Notes: o_held rises once the request has stayed low MIN_CYCLES cycles.
`timescale 1ns/100ps
`default_nettype none

module reset_pulse_filter #(
    parameter int MIN_CYCLES = 2,
    parameter int CNT_W = 20
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_req_n,
    output logic o_held
);

    logic [CNT_W-1:0] low_cnt;

    // ======================================================
    // Width counter, saturates at the qualifying width
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            low_cnt <= '0;
        end else if (i_req_n) begin
            low_cnt <= '0;
        end else if (low_cnt != CNT_W'(MIN_CYCLES)) begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    assign o_held = (low_cnt == CNT_W'(MIN_CYCLES));

endmodule
`default_nettype wire

// >>> core/rtc_alarm_watchdog_supervisor.sv
// Purpose: Alarm, watchdog, square wave and reset supervisor.
// Assumes: Bytewide bus and time fields synchronous to I_CLK.
// Notes: Open-drain pins are a low level plus an enable.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_supervisor_defs.svh"

module rtc_alarm_watchdog_supervisor #(
    parameter int REC_CYCLES = `REC_TIME_MS * (`CLK_HZ / 1000),
    parameter int REQ_B_CYCLES = `REQ_B_MIN_MS * (`CLK_HZ / 1000)
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic [18:0] I_ADDR,
    input wire logic I_CE_N,
    input wire logic I_OE_N,
    input wire logic I_WE_N,
    input wire logic [7:0] I_DQ,
    output logic [7:0] O_DQ,
    output logic O_DQ_OE,
    input wire rtc_supervisor_pkg::bcd_time_t I_TIME,
    input wire logic I_SECOND_TICK,
    input wire logic I_POWER_FAIL,
    input wire logic I_BATTERY_LOW,
    input wire logic I_WATCHDOG_KICK_IN,
    input wire logic I_RESET_REQUEST_A_N,
    input wire logic I_RESET_REQUEST_B_N,
    output logic O_INTERRUPT_FREQ_TEST_OUT_N,
    output logic O_INTERRUPT_FREQ_TEST_OE,
    output logic O_SQUARE_WAVE_OUT,
    output logic O_SQUARE_WAVE_OE,
    output logic O_RESET_OUT_N,
    output logic O_RESET_OUT_OE
);
    import rtc_supervisor_pkg::*;

    localparam int REQ_A_CYCLES =
        (`REQ_A_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int REC_W = $clog2(REC_CYCLES + 1);
    localparam int REQ_W = $clog2(REQ_B_CYCLES + REQ_A_CYCLES + 1);

    // ======================================================
    // Decode helpers
    function automatic logic mapped(input logic [18:0] a);
        mapped = (a == `ADDR_FLAGS) || (a == `ADDR_DAY) ||
                 ((a >= `ADDR_AL_SEC) && (a <= `ADDR_WDOG));
    endfunction

    function automatic logic bcd_eq(input logic [7:0] a,
                                    input logic [7:0] b,
                                    input logic [7:0] m);
        bcd_eq = ((a & m) == (b & m));
    endfunction

    // Match under the scope chosen by the five repeat bits
    function automatic logic alarm_hit(input bcd_time_t t,
                                       input bcd_time_t al,
                                       input logic [4:0] rpt);
        logic s, mi, h, d, mo;
        s = bcd_eq(t.second, al.second, 8'h7F);
        mi = bcd_eq(t.minute, al.minute, 8'h7F);
        h = bcd_eq(t.hour, al.hour, 8'h3F);
        d = bcd_eq(t.date, al.date, 8'h3F);
        mo = bcd_eq(t.month, al.month, 8'h1F);
        case (rpt)
            5'h1E: alarm_hit = s;
            5'h1C: alarm_hit = s & mi;
            5'h18: alarm_hit = s & mi & h;
            5'h10: alarm_hit = s & mi & h & d;
            5'h00: alarm_hit = s & mi & h & d & mo;
            default: alarm_hit = 1'b1;
        endcase
    endfunction

    // Resolution tick: 1/16, 1/4, 1 or 4 s of the divider
    function automatic logic res_tick(input logic [1:0] res,
                                      input logic [`DIV_W-1:0] dv);
        case (res)
            2'h0: res_tick = &dv[11:0];
            2'h1: res_tick = &dv[13:0];
            2'h2: res_tick = &dv[15:0];
            default: res_tick = &dv[17:0];
        endcase
    endfunction

    // ======================================================
    // Bus access tracking
    logic rd_active, rd_q, rd_event;
    logic wr_active, wr_q, wr_commit;
    logic [18:0] addr_q, wr_addr_q;
    logic [7:0] wr_data_q;

    function automatic logic wr_hit(input logic [18:0] a);
        wr_hit = wr_commit && (wr_addr_q == a);
    endfunction

    assign rd_active = !I_CE_N && !I_OE_N && I_WE_N && !I_POWER_FAIL;
    assign wr_active = !I_CE_N && !I_WE_N && !I_POWER_FAIL;
    // A held read sees one snapshot; new data needs a new access
    assign rd_event = rd_active && (!rd_q || I_ADDR != addr_q);
    assign wr_commit = wr_q && !wr_active && !I_POWER_FAIL;

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= '0;
            wr_addr_q <= '0;
            wr_data_q <= 8'h00;
        end else begin
            rd_q <= rd_active;
            wr_q <= wr_active;
            addr_q <= I_ADDR;
            if (wr_active) begin
                wr_addr_q <= I_ADDR;
                wr_data_q <= I_DQ;
            end
        end
    end

    // ======================================================
    // Timebase: fractional divider to a 65536 Hz enable
    logic [31:0] nco;
    logic [32:0] nco_sum;
    logic osc_tick;
    logic [`DIV_W-1:0] div;

    assign nco_sum = {1'b0, nco} + {1'b0, 32'(`NCO_INC)};
    assign osc_tick = nco_sum[32];

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            nco <= 32'h0;
            div <= '0;
        end else begin
            nco <= nco_sum[31:0];
            if (osc_tick) begin
                div <= div + 1'b1;
            end
        end
    end

    // ======================================================
    // Power and reset sequencing
    rst_state_t state;
    logic [REC_W-1:0] rec_cnt;
    logic pf_q, power_down, hold_cond, wd_pending;
    logic [1:0] req_held;
    logic default_clear, wd_end_clear, wd_reset_start;
    logic wd_timeout, watchdog_steering;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_req
            reset_pulse_filter #(
                .MIN_CYCLES(g == 0 ? REQ_A_CYCLES : REQ_B_CYCLES),
                .CNT_W(REQ_W)
            ) u_filter (
                .i_clk(I_CLK),
                .i_rst_b(I_RST_B),
                .i_req_n(g == 0 ? I_RESET_REQUEST_A_N
                                : I_RESET_REQUEST_B_N),
                .o_held(req_held[g])
            );
        end
    endgenerate

    assign power_down = I_POWER_FAIL && !pf_q;
    assign hold_cond = I_POWER_FAIL || (|req_held);
    // Leaving a hold is a power-up: same clears for every source
    assign default_clear = (state == RST_HOLD) && !hold_cond;
    assign wd_end_clear = (state == RST_RECOVER) && !hold_cond &&
                          (rec_cnt == REC_W'(1)) && wd_pending;
    assign wd_reset_start = wd_timeout && watchdog_steering;

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pf_q <= 1'b0;
        end else begin
            pf_q <= I_POWER_FAIL;
        end
    end

    // Starts in recovery so the host sees a power-on reset
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state <= RST_RECOVER;
            rec_cnt <= REC_W'(REC_CYCLES);
            wd_pending <= 1'b0;
        end else begin
            unique case (state)
                RST_IDLE: begin
                    if (hold_cond) begin
                        state <= RST_HOLD;
                    end else if (wd_reset_start) begin
                        state <= RST_RECOVER;
                        rec_cnt <= REC_W'(REC_CYCLES);
                        wd_pending <= 1'b1;
                    end
                end
                RST_HOLD: begin
                    wd_pending <= 1'b0;
                    if (!hold_cond) begin
                        state <= RST_RECOVER;
                        rec_cnt <= REC_W'(REC_CYCLES);
                    end
                end
                RST_RECOVER: begin
                    if (hold_cond) begin
                        state <= RST_HOLD;
                    end else if (rec_cnt == REC_W'(1)) begin
                        state <= RST_IDLE;
                        wd_pending <= 1'b0;
                    end else begin
                        rec_cnt <= rec_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    assign O_RESET_OUT_N = 1'b0;
    assign O_RESET_OUT_OE = (state != RST_IDLE);

    // ======================================================
    // Alarm and control registers
    bcd_time_t alarm;
    logic [3:0] rate;
    logic ft;
    logic [4:0] rpt;
    logic afe, square_wave_enable, abe;

    assign rpt = {alarm.date[`RPT5_BIT], alarm.date[`RPT_BIT],
                  alarm.hour[`RPT_BIT], alarm.minute[`RPT_BIT],
                  alarm.second[`RPT_BIT]};
    assign afe = alarm.month[`MON_AFE];
    assign square_wave_enable = alarm.month[`MON_SQUARE_WAVE_ENABLE];
    assign abe = alarm.month[`MON_ABE];

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            alarm <= '0;
            rate <= 4'h0;
            ft <= 1'b0;
        end else begin
            if (wr_hit(`ADDR_AL_SEC)) alarm.second <= wr_data_q;
            if (wr_hit(`ADDR_AL_MIN)) alarm.minute <= wr_data_q;
            if (wr_hit(`ADDR_AL_HOUR)) alarm.hour <= wr_data_q;
            if (wr_hit(`ADDR_AL_DATE)) alarm.date <= wr_data_q;
            if (wr_hit(`ADDR_AL_MONTH)) alarm.month <= wr_data_q;
            if (wr_hit(`ADDR_FLAGS)) rate <= wr_data_q[`RATE_MSB:0];
            if (wr_hit(`ADDR_DAY)) ft <= wr_data_q[`DAY_FT];
            if (power_down) ft <= 1'b0;
            if (default_clear || wd_end_clear) begin
                alarm.month[`MON_AFE] <= 1'b0;
                alarm.month[`MON_SQUARE_WAVE_ENABLE] <= 1'b0;
                alarm.month[`MON_ABE] <= 1'b0;
                ft <= 1'b0;
            end
        end
    end

    // ======================================================
    // Alarm flag and interrupt
    logic alarm_match, alarm_flag, alarm_irq, flags_read;

    assign alarm_match = I_SECOND_TICK &&
                         alarm_hit(I_TIME, alarm, rpt);
    assign flags_read = rd_event && (I_ADDR == `ADDR_FLAGS);

    // Set wins over the read that clears in the same cycle
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            alarm_flag <= 1'b0;
            alarm_irq <= 1'b0;
        end else begin
            if (alarm_match) begin
                alarm_flag <= 1'b1;
            end else if (flags_read) begin
                alarm_flag <= 1'b0;
            end
            if (alarm_match && afe && (!I_POWER_FAIL || abe)) begin
                alarm_irq <= 1'b1;
            end else if (flags_read) begin
                alarm_irq <= 1'b0;
            end
        end
    end

    // ======================================================
    // Watchdog
    logic [7:0] wd_reg;
    logic [4:0] wd_cnt, wd_mul;
    logic kick_q, wd_restart, wd_flag, wd_irq, wd_zero_wr;

    assign wd_mul = wd_reg[`WD_MUL_MSB:`WD_MUL_LSB];
    assign watchdog_steering = wd_reg[`WD_WDS];
    assign wd_restart = (I_WATCHDOG_KICK_IN != kick_q) ||
                        wr_hit(`ADDR_WDOG);
    assign wd_zero_wr = wr_hit(`ADDR_WDOG) && (wr_data_q == `WD_OFF);
    // Divider is not restarted, so the first unit may be short
    assign wd_timeout = (wd_mul != 5'h00) && !wd_restart && osc_tick &&
        res_tick(wd_reg[`WD_RES_MSB:0], div) &&
        (wd_cnt == 5'h01) && (state == RST_IDLE);

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            kick_q <= 1'b0;
        end else begin
            kick_q <= I_WATCHDOG_KICK_IN;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            wd_reg <= 8'h00;
        end else if (power_down || default_clear || wd_end_clear) begin
            wd_reg <= 8'h00;
        end else if (wr_hit(`ADDR_WDOG)) begin
            wd_reg <= wr_data_q;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            wd_cnt <= 5'h00;
        end else if (wd_restart || wd_timeout) begin
            wd_cnt <= wr_hit(`ADDR_WDOG) ?
                wr_data_q[`WD_MUL_MSB:`WD_MUL_LSB] : wd_mul;
        end else if (osc_tick && res_tick(wd_reg[`WD_RES_MSB:0], div) &&
                     wd_cnt != 5'h00) begin
            wd_cnt <= wd_cnt - 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            wd_flag <= 1'b0;
            wd_irq <= 1'b0;
        end else begin
            if (wd_timeout) begin
                wd_flag <= 1'b1;
            end else if (flags_read) begin
                wd_flag <= 1'b0;
            end
            if (wd_timeout && !watchdog_steering) begin
                wd_irq <= 1'b1;
            end else if (wd_zero_wr || power_down || default_clear) begin
                wd_irq <= 1'b0;
            end
        end
    end

    // ======================================================
    // Shared interrupt / frequency test pin
    logic irq_any, ft_on;

    assign irq_any = alarm_irq || wd_irq;
    assign ft_on = ft && !afe && (watchdog_steering || wd_reg == 8'h00) &&
                   !I_POWER_FAIL;
    assign O_INTERRUPT_FREQ_TEST_OUT_N = 1'b0;
    // Interrupt owns the pin; test tone only when it is idle
    assign O_INTERRUPT_FREQ_TEST_OE = irq_any ||
        (ft_on && !div[`FT_TAP]);

    // ======================================================
    // Square wave
    logic [3:0] tap;

    assign tap = (rate == 4'h1) ? 4'h0 : rate;

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_SQUARE_WAVE_OUT <= 1'b0;
        end else begin
            O_SQUARE_WAVE_OUT <= div[tap];
        end
    end

    assign O_SQUARE_WAVE_OE = square_wave_enable && (rate != 4'h0) &&
                              !I_POWER_FAIL;

    // ======================================================
    // Read data, latched at the start of each access
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (I_ADDR)
            `ADDR_FLAGS: begin
                rd_mux[`FLG_WDF] = wd_flag;
                rd_mux[`FLG_AF] = alarm_flag;
                rd_mux[`FLG_BL] = I_BATTERY_LOW;
                rd_mux[`RATE_MSB:0] = rate;
            end
            `ADDR_AL_SEC: rd_mux = alarm.second;
            `ADDR_AL_MIN: rd_mux = alarm.minute;
            `ADDR_AL_HOUR: rd_mux = alarm.hour;
            `ADDR_AL_DATE: rd_mux = alarm.date;
            `ADDR_AL_MONTH: rd_mux = alarm.month;
            `ADDR_WDOG: rd_mux = wd_reg;
            `ADDR_DAY: rd_mux[`DAY_FT] = ft;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_DQ <= 8'h00;
        end else if (rd_event) begin
            O_DQ <= rd_mux;
        end
    end

    assign O_DQ_OE = rd_q && rd_active && mapped(I_ADDR) &&
                     !rd_event;

endmodule
`default_nettype wire

// >>> testbench/host_bus_model.sv
// Purpose: Host processor model on the bytewide register bus.
// Assumes: Requests change just after a rising clock edge.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/100ps
`default_nettype none

module host_bus_model (
    input wire logic i_clk,
    input wire logic [7:0] i_dq,
    output logic [18:0] o_addr,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [7:0] o_dq
);
    initial begin
        o_addr = 19'h00000;
        o_ce_n = 1'b1;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_dq = 8'h00;
    end

    // ==========================================================
    // Bus cycles
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_dq <= d;
        o_ce_n <= 1'b0;
        o_we_n <= 1'b0;
        @(posedge i_clk);
        o_ce_n <= 1'b1;
        o_we_n <= 1'b1;
        o_dq <= ~d;
        // Commit lands on the next edge; one more so callers see it settled
        repeat (2) @(posedge i_clk);
    endtask

    // Idle cycle after each read, so the next one is a fresh event
    task automatic rd(input logic [18:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_ce_n <= 1'b0;
        o_oe_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        d = i_dq;
        o_ce_n <= 1'b1;
        o_oe_n <= 1'b1;
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// >>> testbench/rtc_supervisor_asserts.sv
// Purpose: Port-level checks of the supervisor.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every supervisor instance.
`timescale 1ns/100ps
`default_nettype none

module rtc_supervisor_asserts #(
    parameter int REC_CYCLES = 20
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic [18:0] I_ADDR,
    input wire logic I_CE_N,
    input wire logic I_OE_N,
    input wire logic I_WE_N,
    input wire logic I_POWER_FAIL,
    input wire logic I_RESET_REQUEST_A_N,
    input wire logic [7:0] O_DQ,
    input wire logic O_DQ_OE,
    input wire logic O_INTERRUPT_FREQ_TEST_OUT_N,
    input wire logic O_SQUARE_WAVE_OE,
    input wire logic O_RESET_OUT_N,
    input wire logic O_RESET_OUT_OE
);
    int rst_len;
    logic rd;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);
    assign rd = !I_CE_N && !I_OE_N && I_WE_N;

    // ==========================================================
    // Length of the current reset output pulse
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_len <= 0;
        end else begin
            rst_len <= O_RESET_OUT_OE ? rst_len + 1 : 0;
        end
    end

    // ==========================================================
    // Checks
    irq_pin_low_a: assert property (!O_INTERRUPT_FREQ_TEST_OUT_N)
        else $error("interrupt pin drives high");
    rst_pin_low_a: assert property (O_RESET_OUT_N == 1'b0)
        else $error("reset pin drives high");
    pf_reset_a: assert property (I_POWER_FAIL |->
        ##[0:1] O_RESET_OUT_OE)
        else $error("no reset output in power fail");
    rec_length_a: assert property ($fell(O_RESET_OUT_OE) |->
        rst_len >= REC_CYCLES - 1)
        else $error("reset output released early");
    req_reset_a: assert property (!I_RESET_REQUEST_A_N [*3] |->
        ##[0:3] O_RESET_OUT_OE)
        else $error("held request gave no reset");
    read_drive_a: assert property (O_DQ_OE |-> rd &&
        (I_ADDR == 19'h7FFF0 || I_ADDR == 19'h7FFFC ||
        (I_ADDR >= 19'h7FFF2 && I_ADDR <= 19'h7FFF7)))
        else $error("data driven outside a mapped read");
    held_read_a: assert property (rd && $past(rd) && $stable(I_ADDR)
        |=> $stable(O_DQ))
        else $error("held read refreshed data");
    sqw_backup_a: assert property (O_SQUARE_WAVE_OE |-> !I_POWER_FAIL)
        else $error("square wave driven in backup");
endmodule

bind rtc_alarm_watchdog_supervisor rtc_supervisor_asserts #(
    .REC_CYCLES(REC_CYCLES)
) chk_u (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
    .I_CE_N(I_CE_N), .I_OE_N(I_OE_N), .I_WE_N(I_WE_N),
    .I_POWER_FAIL(I_POWER_FAIL), .I_RESET_REQUEST_A_N(I_RESET_REQUEST_A_N),
    .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE),
    .O_INTERRUPT_FREQ_TEST_OUT_N(O_INTERRUPT_FREQ_TEST_OUT_N),
    .O_SQUARE_WAVE_OE(O_SQUARE_WAVE_OE), .O_RESET_OUT_N(O_RESET_OUT_N),
    .O_RESET_OUT_OE(O_RESET_OUT_OE)
);
`default_nettype wire

// >>> testbench/rtc_alarm_watchdog_supervisor_bench.sv
// Purpose: Self-checking bench of the supervisor.
// Assumes: Shortened recovery and request B counts.
// Notes: Watchdog expiry is far beyond the run length, so untimed.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_supervisor_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end

module rtc_alarm_watchdog_supervisor_bench;
    import rtc_supervisor_pkg::*;
    localparam int REC = 20;
    logic clk = 1'b0, rst_b = 1'b0, tick = 1'b0, pf = 1'b0, kick = 1'b0;
    logic req_a_n = 1'b1, req_b_n = 1'b1, ce_n, oe_n, we_n, dq_oe;
    logic irq_n, irq_oe, square_wave_out, sqw_oe, rst_n, rst_oe;
    logic [18:0] addr;
    logic [7:0] dq_w, dq_r;
    bcd_time_t tm = 40'h01_01_00_00_00;
    int fail_count = 0, tests_run = 0;

    host_bus_model host_u (.i_clk(clk), .i_dq(dq_r), .o_addr(addr),
        .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_dq(dq_w));
    rtc_alarm_watchdog_supervisor #(.REC_CYCLES(REC), .REQ_B_CYCLES(10))
    dut_u (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_CE_N(ce_n),
        .I_OE_N(oe_n), .I_WE_N(we_n), .I_DQ(dq_w), .O_DQ(dq_r),
        .O_DQ_OE(dq_oe), .I_TIME(tm), .I_SECOND_TICK(tick),
        .I_POWER_FAIL(pf), .I_BATTERY_LOW(1'b0), .I_WATCHDOG_KICK_IN(kick),
        .I_RESET_REQUEST_A_N(req_a_n), .I_RESET_REQUEST_B_N(req_b_n),
        .O_INTERRUPT_FREQ_TEST_OUT_N(irq_n),
        .O_INTERRUPT_FREQ_TEST_OE(irq_oe), .O_SQUARE_WAVE_OUT(square_wave_out),
        .O_SQUARE_WAVE_OE(sqw_oe), .O_RESET_OUT_N(rst_n),
        .O_RESET_OUT_OE(rst_oe));

    always #20 clk = ~clk;

    // ==========================================================
    // Shared tasks
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic sec_tick(input logic [7:0] s);
        @(posedge clk);
        tm.second <= s;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        cyc(2);
    endtask

    task automatic wait_rst_done();
        int n;
        n = 0;
        while (rst_oe !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            fail_count++;
            give_verdict();
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_alarm();
        logic [7:0] d;
        host_u.wr(`ADDR_AL_SEC, 8'h80);
        host_u.wr(`ADDR_AL_MIN, 8'h80);
        host_u.wr(`ADDR_AL_HOUR, 8'h80);
        host_u.wr(`ADDR_AL_DATE, 8'hC0);
        host_u.wr(`ADDR_AL_MONTH, 8'h80);
        sec_tick(8'h17);
        `CHK(irq_oe, 1'b1);
        host_u.rd(`ADDR_FLAGS, d);
        `CHK(d[6], 1'b1);
        `CHK(irq_oe, 1'b0);
        host_u.rd(`ADDR_FLAGS, d);
        `CHK(d[6], 1'b0);
        host_u.wr(`ADDR_AL_SEC, 8'h30);
        sec_tick(8'h29);
        `CHK(irq_oe, 1'b0);
        sec_tick(8'h30);
        `CHK(irq_oe, 1'b1);
        host_u.rd(`ADDR_FLAGS, d);
        host_u.wr(`ADDR_AL_DATE, 8'h40);
        sec_tick(8'h29);
        `CHK(irq_oe, 1'b1);
        host_u.rd(`ADDR_FLAGS, d);
        host_u.wr(`ADDR_AL_DATE, 8'h00);
        host_u.wr(`ADDR_AL_MIN, 8'h00);
        host_u.wr(`ADDR_AL_HOUR, 8'h00);
        sec_tick(8'h30);
        `CHK(irq_oe, 1'b0);
    endtask

    task automatic t_backup();
        logic [7:0] d;
        host_u.wr(`ADDR_AL_DATE, 8'hC0);
        host_u.wr(`ADDR_AL_MONTH, 8'hA0);
        host_u.wr(`ADDR_WDOG, 8'h8E);
        @(posedge clk);
        pf <= 1'b1;
        // Daily alarm: the alarm second still holds 30
        sec_tick(8'h30);
        `CHK(irq_oe, 1'b1);
        `CHK(rst_oe, 1'b1);
        @(posedge clk);
        pf <= 1'b0;
        cyc(REC - 3);
        `CHK(rst_oe, 1'b1);
        wait_rst_done();
        host_u.rd(`ADDR_FLAGS, d);
        `CHK(d[6], 1'b1);
        host_u.rd(`ADDR_AL_MONTH, d);
        `CHK(d, 8'h00);
        host_u.rd(`ADDR_WDOG, d);
        `CHK(d, 8'h00);
    endtask

    task automatic t_wdog();
        logic [7:0] d;
        host_u.wr(`ADDR_WDOG, 8'h0E);
        @(posedge clk);
        kick <= 1'b1;
        host_u.rd(`ADDR_WDOG, d);
        `CHK(d, 8'h0E);
        host_u.wr(`ADDR_WDOG, 8'h00);
        host_u.rd(`ADDR_WDOG, d);
        `CHK(d, 8'h00);
    endtask

    // Test tone shows on the shared pin, then yields to a watchdog armed with interrupt steering
    task automatic t_ft();
        int n;
        host_u.wr(`ADDR_DAY, 8'h40);
        n = 0;
        repeat (25000) @(negedge clk) n += irq_oe;
        `CHK(n > 0, 1'b1);
        host_u.wr(`ADDR_WDOG, 8'h0E);
        n = 0;
        repeat (25000) @(negedge clk) n += irq_oe;
        `CHK(n, 0);
        host_u.wr(`ADDR_WDOG, 8'h00);
    endtask

    // Counting edges over ten periods tolerates the oscillator jitter
    task automatic t_sqw();
        logic [7:0] d;
        logic last;
        int n;
        host_u.wr(`ADDR_FLAGS, 8'hD1);
        host_u.rd(`ADDR_FLAGS, d);
        `CHK(d, 8'h01);
        `CHK(sqw_oe, 1'b0);
        host_u.wr(`ADDR_AL_MONTH, 8'h40);
        `CHK(sqw_oe, 1'b1);
        n = 0;
        last = square_wave_out;
        repeat (7630) begin
            @(negedge clk);
            if (square_wave_out !== last) n++;
            last = square_wave_out;
        end
        `CHK(n >= 19 && n <= 21, 1'b1);
        host_u.wr(`ADDR_FLAGS, 8'h00);
        `CHK(sqw_oe, 1'b0);
    endtask

    task automatic t_req();
        logic [7:0] d;
        @(posedge clk);
        req_a_n <= 1'b0;
        @(posedge clk);
        req_a_n <= 1'b1;
        cyc(5);
        req_b_n <= 1'b0;
        cyc(5);
        req_b_n <= 1'b1;
        cyc(5);
        `CHK(rst_oe, 1'b0);
        req_a_n <= 1'b0;
        cyc(3);
        req_a_n <= 1'b1;
        cyc(3);
        `CHK(rst_oe, 1'b1);
        wait_rst_done();
        host_u.rd(`ADDR_AL_MONTH, d);
        `CHK(d, 8'h00);
        @(posedge clk);
        req_b_n <= 1'b0;
        cyc(12);
        req_b_n <= 1'b1;
        cyc(3);
        `CHK(rst_oe, 1'b1);
        wait_rst_done();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        cyc(5);
        rst_b <= 1'b1;
        wait_rst_done();
        t_alarm();
        t_backup();
        t_wdog();
        t_sqw();
        t_ft();
        t_req();
        give_verdict();
    end
endmodule
`default_nettype wire
